// File: include/pgr_pkg.sv
// Constants for the inset geometry and frame colour register bank.
// Assumes an 8-bit subaddress front end and one 10 MHz processing clock.
package pgr_pkg;

  // ----------------------------------------------------------------
  // Subaddresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_FRAME_COLOR_TWO = 8'h82;
  localparam logic [7:0] ADDR_INSET_LINE_OFFSET = 8'h86;
  localparam logic [7:0] ADDR_WINDOW_VERTICAL_START = 8'h87;
  localparam logic [7:0] ADDR_WINDOW_LINE_COUNT = 8'h88;
  localparam logic [7:0] ADDR_INSET_PIXEL_OFFSET = 8'h89;
  localparam logic [7:0] ADDR_WINDOW_HORIZONTAL_START = 8'h8A;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_FRAME_COLOR_TWO = 16'h501F;
  localparam logic [15:0] RST_INSET_LINE_OFFSET = 16'h0000;
  localparam logic [15:0] RST_WINDOW_VERTICAL_START = 16'h0000;
  localparam logic [15:0] RST_WINDOW_LINE_COUNT = 16'h0000;
  localparam logic [15:0] RST_INSET_PIXEL_OFFSET = 16'h0000;
  localparam logic [15:0] RST_WINDOW_HORIZONTAL_START = 16'h0000;

  // ----------------------------------------------------------------
  // Field layouts
  // ----------------------------------------------------------------
  localparam int CR_LSB = 0;
  localparam int CR_MSB = 4;
  localparam int CB_LSB = 5;
  localparam int CB_MSB = 9;
  localparam int Y_LSB = 10;
  localparam int Y_MSB = 15;
  localparam int CHROMA_PAD = 3;
  localparam int LUMA_PAD = 2;
  localparam int LINE_MSB = 8;
  localparam int LINE_EXT_BIT = 9;
  localparam int PIX_MSB = 7;
  localparam int PIX_EXT_BIT = 8;
  localparam int GROUP_SHIFT = 2;

  // Internal defaults when the external offset setting is off
  localparam logic [8:0] DEF_LINE_OFFSET = 9'h000;
  localparam logic [7:0] DEF_PIXEL_OFFSET = 8'h00;

endpackage : pgr_pkg

// File: logic/pgr_color_unpack.sv
// Expands a packed binary-offset frame colour word into 8-bit Y, Cb, Cr.
// Assumes the packed word comes from a register of the same clock.
`timescale 1ns/1ps

module pgr_color_unpack
  import pgr_pkg::*;
(
  input wire logic [15:0] packed_i,
  output logic [7:0] luma_o,
  output logic [7:0] cb_o,
  output logic [7:0] cr_o
);

  // Dropped low bits come back as zero
  assign cr_o = {packed_i[CR_MSB:CR_LSB], {CHROMA_PAD{1'b0}}};
  assign cb_o = {packed_i[CB_MSB:CB_LSB], {CHROMA_PAD{1'b0}}};
  assign luma_o = {packed_i[Y_MSB:Y_LSB], {LUMA_PAD{1'b0}}};

endmodule : pgr_color_unpack

// File: logic/pgr_window_regs.sv
// Shadowed register bank for the inset geometry and second frame colour.
// Decodes its own subaddresses; assumes the bus front end and command register sit outside, on the same clock.
`timescale 1ns/1ps

module pgr_window_regs
  import pgr_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [7:0] sub_addr_i,
  input wire logic wr_stb_i,
  input wire logic [15:0] wr_data_i,
  input wire logic cmd_wr_i,
  input wire logic field_start_i,
  input wire logic expert_mode_i,
  output logic [15:0] rd_data_o,
  output logic rd_hit_o,
  output logic pending_clear_o,
  output logic pending_o,
  output logic [7:0] frame_luma_o,
  output logic [7:0] frame_cb_o,
  output logic [7:0] frame_cr_o,
  output logic [8:0] line_offset_o,
  output logic [9:0] pixel_offset_o,
  output logic [8:0] vertical_start_o,
  output logic [9:0] horizontal_start_o,
  output logic [8:0] line_count_o,
  output logic line_count_valid_o
);

  // ----------------------------------------------------------------
  // Shadow registers
  // ----------------------------------------------------------------
  logic [15:0] sh_color_q;
  logic [15:0] sh_line_off_q;
  logic [15:0] sh_vstart_q;
  logic [15:0] sh_lcount_q;
  logic [15:0] sh_pix_off_q;
  logic [15:0] sh_hstart_q;

  wire sel_color = sub_addr_i == ADDR_FRAME_COLOR_TWO;
  wire sel_line_off = sub_addr_i == ADDR_INSET_LINE_OFFSET;
  wire sel_vstart = sub_addr_i == ADDR_WINDOW_VERTICAL_START;
  wire sel_lcount = sub_addr_i == ADDR_WINDOW_LINE_COUNT;
  wire sel_pix_off = sub_addr_i == ADDR_INSET_PIXEL_OFFSET;
  wire sel_hstart = sub_addr_i == ADDR_WINDOW_HORIZONTAL_START;
  wire sel_any = sel_color | sel_line_off | sel_vstart | sel_lcount | sel_pix_off | sel_hstart;

  // Whole word kept so readback matches what the host wrote
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sh_color_q <= RST_FRAME_COLOR_TWO;
      sh_line_off_q <= RST_INSET_LINE_OFFSET;
      sh_vstart_q <= RST_WINDOW_VERTICAL_START;
      sh_lcount_q <= RST_WINDOW_LINE_COUNT;
      sh_pix_off_q <= RST_INSET_PIXEL_OFFSET;
      sh_hstart_q <= RST_WINDOW_HORIZONTAL_START;
    end else if (wr_stb_i) begin
      if (sel_color) sh_color_q <= wr_data_i;
      if (sel_line_off) sh_line_off_q <= wr_data_i;
      if (sel_vstart) sh_vstart_q <= wr_data_i;
      if (sel_lcount) sh_lcount_q <= wr_data_i;
      if (sel_pix_off) sh_pix_off_q <= wr_data_i;
      if (sel_hstart) sh_hstart_q <= wr_data_i;
    end
  end

  // ----------------------------------------------------------------
  // Readback
  // ----------------------------------------------------------------
  logic [15:0] rd_data_d;

  assign rd_data_d = sel_color ? sh_color_q :
                     sel_line_off ? sh_line_off_q :
                     sel_vstart ? sh_vstart_q :
                     sel_lcount ? sh_lcount_q :
                     sel_pix_off ? sh_pix_off_q :
                     sel_hstart ? sh_hstart_q : 16'h0000;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_o <= 16'h0000;
      rd_hit_o <= 1'b0;
    end else begin
      rd_data_o <= rd_data_d;
      rd_hit_o <= sel_any;
    end
  end

  // ----------------------------------------------------------------
  // Command handshake
  // ----------------------------------------------------------------
  // Apply waits for a field start so the picture never tears mid-field.
  // A command arriving with the apply keeps the flag up: set beats clear.
  logic pending_q;
  wire apply = pending_q & field_start_i;
  wire pending_d = cmd_wr_i | (pending_q & ~field_start_i);

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pending_q <= 1'b0;
      pending_clear_o <= 1'b0;
    end else begin
      pending_q <= pending_d;
      pending_clear_o <= apply & ~cmd_wr_i;
    end
  end

  assign pending_o = pending_q;

  // ----------------------------------------------------------------
  // Active values
  // ----------------------------------------------------------------
  logic [7:0] luma_w;
  logic [7:0] cb_w;
  logic [7:0] cr_w;

  pgr_color_unpack u_unpack (
    .packed_i(sh_color_q),
    .luma_o(luma_w),
    .cb_o(cb_w),
    .cr_o(cr_w)
  );

  // Reserved upper bits are simply never looked at
  wire [8:0] line_off_eff = sh_line_off_q[LINE_EXT_BIT] ?
                            sh_line_off_q[LINE_MSB:0] : DEF_LINE_OFFSET;
  wire [7:0] pix_off_sel = sh_pix_off_q[PIX_EXT_BIT] ?
                           sh_pix_off_q[PIX_MSB:0] : DEF_PIXEL_OFFSET;
  wire [9:0] pix_off_eff = {pix_off_sel, {GROUP_SHIFT{1'b0}}};
  wire [9:0] hstart_eff = {sh_hstart_q[PIX_MSB:0], {GROUP_SHIFT{1'b0}}};

  // Same start value serves source segment (write role) or inset (display role)
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      frame_luma_o <= {RST_FRAME_COLOR_TWO[Y_MSB:Y_LSB], {LUMA_PAD{1'b0}}};
      frame_cb_o <= {RST_FRAME_COLOR_TWO[CB_MSB:CB_LSB], {CHROMA_PAD{1'b0}}};
      frame_cr_o <= {RST_FRAME_COLOR_TWO[CR_MSB:CR_LSB], {CHROMA_PAD{1'b0}}};
      line_offset_o <= DEF_LINE_OFFSET;
      pixel_offset_o <= {DEF_PIXEL_OFFSET, {GROUP_SHIFT{1'b0}}};
      vertical_start_o <= RST_WINDOW_VERTICAL_START[LINE_MSB:0];
      horizontal_start_o <= {RST_WINDOW_HORIZONTAL_START[PIX_MSB:0], {GROUP_SHIFT{1'b0}}};
      line_count_o <= RST_WINDOW_LINE_COUNT[LINE_MSB:0];
      line_count_valid_o <= 1'b0;
    end else if (apply) begin
      frame_luma_o <= luma_w;
      frame_cb_o <= cb_w;
      frame_cr_o <= cr_w;
      line_offset_o <= line_off_eff;
      pixel_offset_o <= pix_off_eff;
      vertical_start_o <= sh_vstart_q[LINE_MSB:0];
      horizontal_start_o <= hstart_eff;
      line_count_o <= sh_lcount_q[LINE_MSB:0];
      line_count_valid_o <= expert_mode_i;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_apply;
    pending_q && field_start_i;
  endsequence

  sequence s_quiet;
    !pending_q && !cmd_wr_i;
  endsequence

  chk_color_packing: assert property (
    @(posedge clock_i) disable iff (rst_i)
    s_apply |=> frame_luma_o == {$past(sh_color_q[Y_MSB:Y_LSB]), 2'b00} &&
                frame_cb_o == {$past(sh_color_q[CB_MSB:CB_LSB]), 3'b000} &&
                frame_cr_o == {$past(sh_color_q[CR_MSB:CR_LSB]), 3'b000})
    else $error("frame colour not unpacked correctly");

  chk_shadow_hold: assert property (
    @(posedge clock_i) disable iff (rst_i)
    !(pending_q && field_start_i) |=> $stable(vertical_start_o) && $stable(line_count_o))
    else $error("active value changed without an apply");

  chk_line_offset: assert property (
    @(posedge clock_i) disable iff (rst_i)
    s_apply ##0 !sh_line_off_q[LINE_EXT_BIT] |=> line_offset_o == DEF_LINE_OFFSET)
    else $error("line offset ignored its enable bit");

  chk_pixel_offset: assert property (
    @(posedge clock_i) disable iff (rst_i)
    s_apply ##0 sh_pix_off_q[PIX_EXT_BIT] |=>
      pixel_offset_o == {$past(sh_pix_off_q[PIX_MSB:0]), 2'b00})
    else $error("pixel offset not four times the field");

  chk_vstart_apply: assert property (
    @(posedge clock_i) disable iff (rst_i)
    s_apply |=> vertical_start_o == $past(sh_vstart_q[LINE_MSB:0]))
    else $error("vertical start not applied");

  chk_hstart_groups: assert property (
    @(posedge clock_i) disable iff (rst_i)
    s_apply |=> horizontal_start_o == {$past(sh_hstart_q[PIX_MSB:0]), 2'b00})
    else $error("horizontal start not in four-pixel groups");

  chk_count_expert: assert property (
    @(posedge clock_i) disable iff (rst_i)
    s_apply ##0 !expert_mode_i |=> !line_count_valid_o)
    else $error("line count marked valid outside expert mode");

  chk_flag_clear: assert property (
    @(posedge clock_i) disable iff (rst_i)
    s_apply ##0 !cmd_wr_i |=> pending_clear_o && !pending_q ##1 !pending_clear_o)
    else $error("pending flag not cleared after apply");

  chk_flag_set: assert property (
    @(posedge clock_i) disable iff (rst_i)
    cmd_wr_i |=> pending_q)
    else $error("command write lost");

  chk_idle_no_clear: assert property (
    @(posedge clock_i) disable iff (rst_i)
    s_quiet |=> !pending_clear_o)
    else $error("clear pulse without a pending command");

  chk_readback: assert property (
    @(posedge clock_i) disable iff (rst_i)
    wr_stb_i && sel_vstart ##1 sub_addr_i == ADDR_WINDOW_VERTICAL_START && !wr_stb_i
      |=> rd_data_o == $past(wr_data_i, 2))
    else $error("readback is not the latest shadow");

endmodule : pgr_window_regs

// File: verification/pgr_host_model.sv
// Host model: the serial-bus front end that programs the inset register bank.
// Assumes the bank samples every input except the asynchronous rst_i on the rising edge of clock_i.
`timescale 1ns/1ps

module pgr_host_model (
  input wire logic clock_i,
  input wire logic pending_clear_i,
  input wire logic [15:0] rd_data_i,
  input wire logic rd_hit_i,
  output logic [7:0] sub_addr_o,
  output logic wr_stb_o,
  output logic [15:0] wr_data_o,
  output logic cmd_wr_o,
  output logic [7:0] cmd_reg_o
);
  initial begin
    sub_addr_o = 8'h00;
    wr_stb_o = 1'b0;
    wr_data_o = 16'h0000;
    cmd_wr_o = 1'b0;
    cmd_reg_o = 8'h00;
  end

  // Reserved upper bits go out as zero for 8'h86, 8'h88 and 8'h89 only; 8'h87 and 8'h8A are not masked
  task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] m;
    m = (a == 8'h86) ? 16'h03FF : (a == 8'h88 || a == 8'h89) ? 16'h01FF : 16'hFFFF;
    @(posedge clock_i);
    sub_addr_o <= a;
    wr_data_o <= d & m;
    wr_stb_o <= 1'b1;
    @(posedge clock_i);
    wr_stb_o <= 1'b0;
  endtask : write_reg

  task automatic read_reg(input logic [7:0] a, output logic [15:0] d, output logic h);
    @(posedge clock_i);
    sub_addr_o <= a;
    @(posedge clock_i);
    #1;
    d = rd_data_i;
    h = rd_hit_i;
  endtask : read_reg

  task automatic send_cmd();
    @(posedge clock_i);
    cmd_reg_o[7] <= 1'b1;
    cmd_wr_o <= 1'b1;
    @(posedge clock_i);
    cmd_wr_o <= 1'b0;
    #1;
  endtask : send_cmd

  // Completion drops the new-command flag
  always @(posedge clock_i) begin
    if (pending_clear_i) begin
      cmd_reg_o[7] <= 1'b0;
    end
  end
endmodule : pgr_host_model

// File: verification/tb.sv
// Testbench for the shadowed inset register bank.
// Assumes the host model drives all bus-side inputs; the bench drives field and mode.
`timescale 1ns/1ps

module tb;
  import pgr_pkg::*;
  logic clock_i, rst_i, field_start_i, expert_mode_i, wr_stb_i, cmd_wr_i, hit, rd_hit_o;
  logic pending_clear_o, pending_o, line_count_valid_o;
  logic [7:0] sub_addr_i, frame_luma_o, frame_cb_o, frame_cr_o, cmd_reg;
  logic [15:0] wr_data_i, rd_data_o, rd;
  logic [8:0] line_offset_o, vertical_start_o, line_count_o;
  logic [9:0] pixel_offset_o, horizontal_start_o;
  int err_total, cmp_count, cyc;

  // ----------------------------------------------------------------
  // Clock, reset, instances
  // ----------------------------------------------------------------
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  pgr_host_model pgr_host_model_i (.clock_i(clock_i), .pending_clear_i(pending_clear_o),
    .rd_data_i(rd_data_o), .rd_hit_i(rd_hit_o), .sub_addr_o(sub_addr_i), .wr_stb_o(wr_stb_i),
    .wr_data_o(wr_data_i), .cmd_wr_o(cmd_wr_i), .cmd_reg_o(cmd_reg));

  pgr_window_regs pgr_window_regs_i (.clock_i(clock_i), .rst_i(rst_i),
    .sub_addr_i(sub_addr_i), .wr_stb_i(wr_stb_i), .wr_data_i(wr_data_i), .cmd_wr_i(cmd_wr_i),
    .field_start_i(field_start_i), .expert_mode_i(expert_mode_i), .rd_data_o(rd_data_o),
    .rd_hit_o(rd_hit_o), .pending_clear_o(pending_clear_o), .pending_o(pending_o),
    .frame_luma_o(frame_luma_o), .frame_cb_o(frame_cb_o), .frame_cr_o(frame_cr_o),
    .line_offset_o(line_offset_o), .pixel_offset_o(pixel_offset_o),
    .vertical_start_o(vertical_start_o), .horizontal_start_o(horizontal_start_o),
    .line_count_o(line_count_o), .line_count_valid_o(line_count_valid_o));

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic field_pulse();
    @(posedge clock_i);
    field_start_i <= 1'b1;
    @(posedge clock_i);
    field_start_i <= 1'b0;
    #1;
  endtask : field_pulse

  // Active outputs as one packed word set, compared field by field
  task automatic chk_out(input logic [15:0] c, input logic [8:0] lo, input logic [9:0] po,
                         input logic [8:0] vs, input logic [9:0] hs, input logic [8:0] lc,
                         input logic v);
    chk("luma", {c[15:10], 2'b00}, frame_luma_o);
    chk("cb", {c[9:5], 3'b000}, frame_cb_o);
    chk("cr", {c[4:0], 3'b000}, frame_cr_o);
    chk("line_off", lo, line_offset_o);
    chk("pix_off", po, pixel_offset_o);
    chk("vstart", vs, vertical_start_o);
    chk("hstart", hs, horizontal_start_o);
    chk("lcount", lc, line_count_o);
    chk("lc_valid", v, line_count_valid_o);
  endtask : chk_out

  task automatic test_reset();
    logic [7:0] a [6] = '{8'h82, 8'h86, 8'h87, 8'h88, 8'h89, 8'h8A};
    foreach (a[i]) begin
      pgr_host_model_i.read_reg(a[i], rd, hit);
      chk("reset_rd", (i == 0) ? 16'h501F : 16'h0000, rd);
      chk("reset_hit", 16'h0001, hit);
    end
    pgr_host_model_i.read_reg(8'h83, rd, hit);
    chk("unmapped_rd", 16'h0000, rd);
    chk("unmapped_hit", 16'h0000, hit);
    chk_out(16'h501F, 9'h000, 10'h000, 9'h000, 10'h000, 9'h000, 1'b0);
    $display("test_reset done");
  endtask : test_reset

  // Writes land in the shadow only; a field edge without a command changes nothing
  task automatic test_apply(input logic ext, input logic xm);
    logic [15:0] c;
    c = {6'h2D, 5'h13, 5'h0E};
    @(posedge clock_i);
    expert_mode_i <= xm;
    pgr_host_model_i.write_reg(8'h82, c);
    pgr_host_model_i.write_reg(8'h86, {6'h00, ext, 9'h1A5});
    pgr_host_model_i.write_reg(8'h89, {7'h00, ext, 8'hC3});
    pgr_host_model_i.write_reg(8'h87, 16'h0123);
    pgr_host_model_i.write_reg(8'h8A, 16'h005A);
    pgr_host_model_i.write_reg(8'h88, 16'h00F1);
    pgr_host_model_i.read_reg(8'h86, rd, hit);
    chk("shadow_rd", {6'h00, ext, 9'h1A5}, rd);
    field_pulse();
    if (!ext) begin
      chk("no_cmd_luma", 16'h0050, frame_luma_o);
    end
    chk("no_cmd_pix_off", 16'h0000, pixel_offset_o);
    pgr_host_model_i.send_cmd();
    chk("pending", 16'h0001, pending_o);
    field_pulse();
    chk("clear_pulse", 16'h0001, pending_clear_o);
    chk_out(c, ext ? 9'h1A5 : 9'h000, ext ? 10'h30C : 10'h000, 9'h123, 10'h168,
            9'h0F1, xm);
    @(posedge clock_i);
    #1;
    chk("flag_done", 16'h0000, {pending_clear_o, pending_o, cmd_reg[7]});
    $display("test_apply ext=%0b done", ext);
  endtask : test_apply

  // A command landing on the apply edge keeps the flag up and defers the clear
  task automatic test_collide();
    pgr_host_model_i.write_reg(8'h87, 16'h00AB);
    pgr_host_model_i.send_cmd();
    fork
      pgr_host_model_i.send_cmd();
      field_pulse();
    join
    chk("collide_vstart", 16'h00AB, vertical_start_o);
    chk("collide_pending", 16'h0001, pending_o);
    chk("collide_no_clear", 16'h0000, pending_clear_o);
    field_pulse();
    chk("collide_clear", 16'h0001, pending_clear_o);
    chk("collide_flag", 16'h0000, pending_o);
    @(posedge clock_i);
    #1;
    chk("collide_done", 16'h0000, {pending_clear_o, cmd_reg[7]});
    $display("test_collide done");
  endtask : test_collide

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      wrap_up();
    end
  end

  initial begin
    rst_i = 1'b1;
    field_start_i = 1'b0;
    expert_mode_i = 1'b0;
    repeat (10) @(posedge clock_i);
    rst_i <= 1'b0;
    test_reset();
    test_apply(1'b0, 1'b0);
    test_apply(1'b1, 1'b1);
    test_collide();
    wrap_up();
  end
endmodule : tb
